// File: board_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// board reset supervisor and boot strap drive
// ************************************************************
module board_supervisor (
  // clock
  input  wire logic        clk,
  // requests from the bench
  input  wire logic        por_req,
  input  wire logic        warm_req,
  input  wire logic [22:0] strap_val,
  // reset pins and straps {host sel, bank, address}
  output var  logic        por_n,
  output var  logic        warm_reset_n,
  output var  logic [22:0] straps
);
  int cnt = 0;

  // pins start released, straps at zero
  initial begin
    por_n = 1'b1;
    warm_reset_n = 1'b1;
    straps = 23'h000000;
  end

  // low pulse of the chosen pin, straps held 20 cycles past release
  always @(posedge clk) begin
    if (por_req || warm_req) begin
      por_n <= !por_req;
      warm_reset_n <= !warm_req;
      straps <= strap_val;
      cnt <= (por_req ? 256 : 24) + 20;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 21) begin
        por_n <= 1'b1;
        warm_reset_n <= 1'b1;
      end
      // straps let go 20 cycles after pin release, by inverting them
      if (cnt == 1) straps <= ~straps;
    end
  end
endmodule // board_supervisor
`default_nettype wire

// File: reset_pin_state_and_clock_tree.v
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_regs.vh"

module reset_pin_state_and_clock_tree #(
  parameter Z_WIDTH     = 8,
  parameter INIT_CYCLES = `STAT_MAX_CYCLES - `STAT_MARGIN
) (
  // clock and reset
  input  wire                clk,
  input  wire                srst,
  // reset pins and internal reset request
  input  wire                por_n,
  input  wire                warm_reset_n,
  input  wire                max_reset_req,
  output wire                reset_status_out_n,
  // boot configuration pins
  input  wire [19:0]         ext_address_boot_pins,
  input  wire [1:0]          ext_bank_boot_pins,
  input  wire                host_bus_select_pin,
  // peripheral drive requests
  input  wire [Z_WIDTH-1:0]  periph_z_data,
  input  wire [Z_WIDTH-1:0]  periph_z_oe,
  input  wire [4:0]          periph_cell_tx_data,
  input  wire                periph_cell_tx_enable,
  input  wire                periph_bus_hold,
  input  wire                periph_bus_request,
  input  wire                periph_host_ready,
  // pin groups
  output wire [Z_WIDTH-1:0]  zgroup_out,
  output wire [Z_WIDTH-1:0]  zgroup_oe,
  output wire [4:0]          cell_tx_data_out,
  output wire                cell_tx_enable_out,
  output wire                ext_bus_hold_out,
  output wire                ext_bus_request_out,
  output wire                host_ready_out,
  // clock tree controls and ticks
  output wire                pll_enable_out,
  output wire [4:0]          pll_multiplier,
  output wire [4:0]          pre_divider,
  output wire [4:0]          secondary_pll_mult,
  output wire                system_reference_clock,
  output wire                core_clk_tick,
  output wire [3:0]          sys_clk_tick,
  output wire                secondary_sys_clock_a,
  // latched boot values and peripheral enables
  output wire [19:0]         boot_addr_latched,
  output wire [1:0]          boot_bank_latched,
  output wire                boot_host_sel_latched,
  output wire [3:0]          periph_enable,
  // register port
  input  wire [7:0]          reg_addr,
  input  wire [31:0]         reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output wire [31:0]         reg_rdata
);

  // ************************************************************
  // reset sequencing
  // ************************************************************
  localparam ST_RESET = 2'b00;
  localparam ST_WAIT  = 2'b01;
  localparam ST_RUN   = 2'b10;

  // stretch length for an internal warm request, cut to the counter width below
  localparam integer WARM_CYCLES = `WARM_MIN_CYCLES;

  reg  [1:0]  state_reg;
  reg  [13:0] init_cnt_reg;
  reg  [4:0]  max_cnt_reg;
  reg         status_reg;
  reg         por_seen_reg;
  reg         warm_seen_reg;
  wire        por_active;
  wire        warm_active;
  wire        any_reset;
  wire        release_now;

  // max reset is stretched to the warm minimum and merged with the pin
  assign por_active  = srst | ~por_n;
  assign warm_active = ~warm_reset_n | max_reset_req | (max_cnt_reg != 5'h00);
  assign any_reset   = por_active | warm_active;
  assign release_now = (state_reg == ST_RESET) & ~any_reset;

  // internal warm request pulse width stretcher
  always @(posedge clk) begin
    if (srst) begin
      max_cnt_reg <= 5'h00;
    end else if (max_reset_req) begin
      max_cnt_reg <= WARM_CYCLES[4:0];
    end else if (max_cnt_reg != 5'h00) begin
      max_cnt_reg <= max_cnt_reg - 5'h01;
    end
  end

  // reset state machine and status output
  always @(posedge clk) begin
    if (any_reset) begin
      state_reg    <= ST_RESET;
      init_cnt_reg <= 14'h0000;
      status_reg   <= 1'b0;
    end else begin
      case (state_reg)
        ST_RESET: begin
          state_reg    <= ST_WAIT;
          init_cnt_reg <= 14'h0000;
        end
        ST_WAIT: begin
          if (init_cnt_reg == INIT_CYCLES[13:0] - 14'h0001) begin
            state_reg  <= ST_RUN;
            status_reg <= 1'b1;
          end else begin
            init_cnt_reg <= init_cnt_reg + 14'h0001;
          end
        end
        ST_RUN: begin
          status_reg <= 1'b1;
        end
        default: begin
          state_reg <= ST_RESET;
        end
      endcase
    end
  end

  // cause of the most recent reset, power-on wins
  always @(posedge clk) begin
    if (por_active) begin
      por_seen_reg  <= 1'b1;
      warm_seen_reg <= 1'b0;
    end else if (warm_active) begin
      por_seen_reg  <= 1'b0;
      warm_seen_reg <= 1'b1;
    end
  end

  assign reset_status_out_n = status_reg;

  // ************************************************************
  // boot pin latch
  // ************************************************************
  reg [19:0] boot_addr_reg;
  reg [1:0]  boot_bank_reg;
  reg        boot_host_reg;

  // pins are sampled in the first cycle with all resets released
  always @(posedge clk) begin
    if (srst) begin
      boot_addr_reg <= 20'h00000;
      boot_bank_reg <= 2'h0;
      boot_host_reg <= 1'b0;
    end else if (release_now) begin
      boot_addr_reg <= ext_address_boot_pins;
      boot_bank_reg <= ext_bank_boot_pins;
      boot_host_reg <= host_bus_select_pin;
    end
  end

  assign boot_addr_latched     = boot_addr_reg;
  assign boot_bank_latched     = boot_bank_reg;
  assign boot_host_sel_latched = boot_host_reg;

  // ************************************************************
  // registers
  // ************************************************************
  reg  [3:0]  pcfg_reg;
  reg         pll_en_reg;
  reg  [4:0]  mult_reg;
  reg  [4:0]  pre_divider_reg;
  reg  [4:0]  div4_ratio_reg;
  reg  [4:0]  div5_ratio_reg;
  reg         div4_en_reg;
  reg         div5_en_reg;
  reg  [31:0] rdata_reg;
  wire        wr_ok;

  // software writes are ignored while the device is held in reset
  assign wr_ok = reg_wr & (state_reg == ST_RUN);

  // peripheral enables clear only on power-on
  always @(posedge clk) begin
    if (por_active) begin
      pcfg_reg <= `PCFG_RESET;
    end else if (wr_ok && reg_addr == `OFS_PERIPH_CFG) begin
      pcfg_reg <= reg_wdata[`PCFG_WIDTH-1:0];
    end
  end

  // clock controller defaults on power-on, warm and max reset
  always @(posedge clk) begin
    if (any_reset) begin
      pll_en_reg     <= 1'b0;
      mult_reg       <= `PLL_MULT_RESET;
      pre_divider_reg     <= `PRE_DIV_RESET;
      div4_ratio_reg <= `DIV_RATIO_RESET;
      div5_ratio_reg <= `DIV_RATIO_RESET;
      div4_en_reg    <= `DIV_EN_RESET;
      div5_en_reg    <= `DIV_EN_RESET;
    end else if (wr_ok) begin
      case (reg_addr)
        `OFS_PLL_CTRL: pll_en_reg <= reg_wdata[`PLL_EN_BIT];
        `OFS_PLL_MULT: mult_reg <= reg_wdata[`DIV_RATIO_W-1:0];
        `OFS_PRE_DIV:  pre_divider_reg <= reg_wdata[`DIV_RATIO_W-1:0];
        `OFS_DIV_FOUR: begin
          div4_ratio_reg <= reg_wdata[`DIV_RATIO_W-1:0];
          div4_en_reg    <= reg_wdata[`DIV_EN_BIT];
        end
        `OFS_DIV_FIVE: begin
          div5_ratio_reg <= reg_wdata[`DIV_RATIO_W-1:0];
          div5_en_reg    <= reg_wdata[`DIV_EN_BIT];
        end
        default: begin
          pll_en_reg <= pll_en_reg;
        end
      endcase
    end
  end

  // read data valid in the cycle after the strobe only
  always @(posedge clk) begin
    if (srst | ~reg_rd) begin
      rdata_reg <= 32'h00000000;
    end else begin
      case (reg_addr)
        `OFS_PERIPH_CFG: rdata_reg <= {28'h0000000, pcfg_reg};
        `OFS_PLL_CTRL:   rdata_reg <= {31'h00000000, pll_en_reg};
        `OFS_PLL_MULT:   rdata_reg <= {27'h0000000, mult_reg};
        `OFS_PRE_DIV:    rdata_reg <= {27'h0000000, pre_divider_reg};
        `OFS_DIV_FOUR:   rdata_reg <= {16'h0000, div4_en_reg, 10'h000, div4_ratio_reg};
        `OFS_DIV_FIVE:   rdata_reg <= {16'h0000, div5_en_reg, 10'h000, div5_ratio_reg};
        `OFS_STATUS:     rdata_reg <= {26'h0000000, boot_bank_reg, boot_host_reg,
                                       warm_seen_reg, por_seen_reg, status_reg};
        `OFS_BOOT_ADDR:  rdata_reg <= {12'h000, boot_addr_reg};
        default:         rdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign reg_rdata      = rdata_reg;
  assign periph_enable  = pcfg_reg;
  assign pll_enable_out = pll_en_reg;
  assign pll_multiplier = mult_reg;
  assign pre_divider    = pre_divider_reg;

  // ************************************************************
  // clock tree dividers
  // ************************************************************
  wire [19:0] ratio_bus;
  wire [3:0]  div_en_bus;
  wire [3:0]  tick_bus;
  reg  [4:0]  core_cnt_reg;
  reg         core_tick_reg;
  reg  [4:0]  sec_cnt_reg;
  reg         sec_tick_reg;
  wire [4:0]  core_ratio;

  assign ratio_bus  = {div5_ratio_reg, div4_ratio_reg, `DIV_THREE_RATIO, `DIV_TWO_RATIO};
  assign div_en_bus = {div5_en_reg, div4_en_reg, 1'b1, 1'b1};
  assign core_ratio = pll_en_reg ? `CORE_PLL_RATIO : `CORE_BYPASS_RATIO;

  // divide-by-(n+1) tick from a down counter
  function [5:0] div_step;
    input [4:0] cnt;
    input [4:0] ratio;
    begin
      if (cnt == 5'h00) begin
        div_step = {1'b1, ratio};
      end else begin
        div_step = {1'b0, cnt - 5'h01};
      end
    end
  endfunction

  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_div
      reg  [4:0] cnt_reg;
      reg        tick_reg;
      wire [5:0] step;
      assign step = div_step(cnt_reg, ratio_bus[k*5 +: 5]);
      // each output divider restarts from its default on any reset
      always @(posedge clk) begin
        if (any_reset | ~div_en_bus[k]) begin
          cnt_reg  <= 5'h00;
          tick_reg <= 1'b0;
        end else begin
          cnt_reg  <= step[4:0];
          tick_reg <= step[5];
        end
      end
      // one driver per tick bit
      assign tick_bus[k] = tick_reg;
    end
  endgenerate

  // core clock and secondary system clock ticks
  always @(posedge clk) begin
    if (srst) begin
      core_cnt_reg  <= 5'h00;
      core_tick_reg <= 1'b0;
      sec_cnt_reg   <= 5'h00;
      sec_tick_reg  <= 1'b0;
    end else begin
      {core_tick_reg, core_cnt_reg} <= div_step(core_cnt_reg, core_ratio);
      {sec_tick_reg, sec_cnt_reg}   <= div_step(sec_cnt_reg, `SEC_SYS_A_RATIO);
    end
  end

  assign system_reference_clock = ~srst; // bypass: reference runs every cycle
  assign core_clk_tick          = core_tick_reg;
  assign sys_clk_tick           = tick_bus;
  assign secondary_sys_clock_a  = sec_tick_reg;
  assign secondary_pll_mult     = `SEC_PLL_MULT;

  // ************************************************************
  // pin groups
  // ************************************************************
  reg [Z_WIDTH-1:0] z_out_reg;
  reg [Z_WIDTH-1:0] z_oe_reg;
  reg [4:0]         cell_data_reg;
  reg               cell_en_reg;
  reg               hold_reg;
  reg               busreq_reg;
  reg               hrdy_reg;
  wire              owned;

  assign owned = (state_reg != ST_RESET);

  // pins keep their reset state until their peripheral is enabled, except zgroup_out, which follows periph_z_data whenever no reset is active
  always @(posedge clk) begin
    if (any_reset) begin
      z_out_reg     <= {Z_WIDTH{1'b0}};
      z_oe_reg      <= {Z_WIDTH{1'b0}};
      cell_data_reg <= 5'h00;
      cell_en_reg   <= 1'b0;
      hold_reg      <= 1'b1;
      busreq_reg    <= 1'b1;
      hrdy_reg      <= 1'b1;
    end else begin
      z_out_reg     <= periph_z_data;
      z_oe_reg      <= (owned & pcfg_reg[`PCFG_ZGROUP]) ? periph_z_oe : {Z_WIDTH{1'b0}};
      cell_data_reg <= pcfg_reg[`PCFG_CELL_TX] ? periph_cell_tx_data : 5'h00;
      cell_en_reg   <= pcfg_reg[`PCFG_CELL_TX] & periph_cell_tx_enable;
      hold_reg      <= pcfg_reg[`PCFG_EXT_MEM] ? periph_bus_hold : 1'b1;
      busreq_reg    <= pcfg_reg[`PCFG_EXT_MEM] ? periph_bus_request : 1'b1;
      hrdy_reg      <= pcfg_reg[`PCFG_HOST] ? periph_host_ready : 1'b1;
    end
  end

  assign zgroup_out          = z_out_reg;
  assign zgroup_oe           = z_oe_reg;
  assign cell_tx_data_out    = cell_data_reg;
  assign cell_tx_enable_out  = cell_en_reg;
  assign ext_bus_hold_out    = hold_reg;
  assign ext_bus_request_out = busreq_reg;
  assign host_ready_out      = hrdy_reg;

endmodule // reset_pin_state_and_clock_tree

`default_nettype wire

// File: reset_pin_state_and_clock_tree_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// port checker for the reset sequencer
// ************************************************************
module reset_seq_checker #(
  parameter Z_WIDTH     = 8,
  parameter INIT_CYCLES = 20
) (
  // clock, reset and reset pins
  input wire logic               clk,
  input wire logic               srst,
  input wire logic               por_n,
  input wire logic               warm_reset_n,
  input wire logic               max_reset_req,
  input wire logic               reset_status_out_n,
  // pin groups
  input wire logic               periph_bus_request,
  input wire logic [Z_WIDTH-1:0] zgroup_oe,
  input wire logic [4:0]         cell_tx_data_out,
  input wire logic               cell_tx_enable_out,
  input wire logic               ext_bus_hold_out,
  input wire logic               ext_bus_request_out,
  input wire logic               host_ready_out,
  // clock tree and enables
  input wire logic               pll_enable_out,
  input wire logic [4:0]         secondary_pll_mult,
  input wire logic               core_clk_tick,
  input wire logic [3:0]         sys_clk_tick,
  input wire logic               secondary_sys_clock_a,
  input wire logic [3:0]         periph_enable
);
  localparam int RISE_MAX = INIT_CYCLES + 28;
  logic [15:0] clr_cnt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // cycles since every reset source went quiet, saturating
  always @(posedge clk) begin
    if (srst || !por_n || !warm_reset_n || max_reset_req) clr_cnt <= 16'h0000;
    else if (clr_cnt != 16'hffff) clr_cnt <= clr_cnt + 16'h0001;
  end

  AST_Z_FLOAT: assert property (!periph_enable[3] && $past(!periph_enable[3]) |-> zgroup_oe == '0)
    else $error("z group driven while disabled");
  AST_LOW_GROUP: assert property (!periph_enable[1] && $past(!periph_enable[1])
    |-> cell_tx_data_out == 5'h00 && !cell_tx_enable_out) else $error("low group not low");
  AST_HIGH_GROUP: assert property (!periph_enable[0] && $past(!periph_enable[0])
    |-> ext_bus_hold_out && ext_bus_request_out) else $error("hold or request not high");
  AST_HOST_READY: assert property (!periph_enable[2] && $past(!periph_enable[2]) |-> host_ready_out)
    else $error("host ready not high");
  AST_BUSREQ_FOLLOW: assert property (periph_enable[0] && $past(periph_enable[0]) && reset_status_out_n
    && $past(reset_status_out_n) && $stable(periph_bus_request) |-> ext_bus_request_out == periph_bus_request)
    else $error("bus request does not follow peripheral");
  AST_POR_CLEARS: assert property (!por_n |=> periph_enable == 4'h0)
    else $error("peripheral enabled after power-on");
  AST_STATUS_DROP: assert property (!por_n || !warm_reset_n || max_reset_req |=> !reset_status_out_n)
    else $error("status high during reset");
  AST_STATUS_HELD: assert property (clr_cnt < INIT_CYCLES |-> !reset_status_out_n)
    else $error("status released early");
  AST_STATUS_RISE: assert property (clr_cnt > RISE_MAX |-> reset_status_out_n)
    else $error("status not released in time");
  AST_CORE_DIV3: assert property (disable iff (srst || !reset_status_out_n)
    (core_clk_tick && !pll_enable_out) ##1 (!pll_enable_out) [*3]
    |-> core_clk_tick && !$past(core_clk_tick) && !$past(core_clk_tick, 2)) else $error("core not ref/3");
  AST_SYS_DIV3: assert property (disable iff (srst || !reset_status_out_n)
    sys_clk_tick[0] |=> !sys_clk_tick[0] [*2] ##1 sys_clk_tick[0]) else $error("second clock not /3");
  AST_SYS_DIV6: assert property (disable iff (srst || !reset_status_out_n)
    sys_clk_tick[1] |=> !sys_clk_tick[1] [*5] ##1 sys_clk_tick[1]) else $error("third clock not /6");
  AST_SEC_CLOCKS: assert property (secondary_sys_clock_a |=> !secondary_sys_clock_a
    ##1 (secondary_sys_clock_a && secondary_pll_mult == 5'h0a)) else $error("secondary clocks wrong");
  AST_MAX_AS_WARM: assert property ($rose(max_reset_req)
    |=> (!reset_status_out_n && !pll_enable_out) [*8]) else $error("max reset not like warm");

  // main scenarios
  COV_RISE: cover property ($rose(reset_status_out_n));
  COV_BUSREQ: cover property (periph_enable[0] && reset_status_out_n && !ext_bus_request_out);
  COV_MAX: cover property ($rose(max_reset_req));
endmodule // reset_seq_checker

bind reset_pin_state_and_clock_tree reset_seq_checker #(
  .Z_WIDTH(Z_WIDTH), .INIT_CYCLES(INIT_CYCLES)) u_chk (.*);
`default_nettype wire

// File: reset_pin_state_and_clock_tree_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_regs.vh"
// ************************************************************
// testbench
// ************************************************************
module reset_pin_state_and_clock_tree_tb;
  localparam int INIT = 20;
  logic clk = 1'b0, srst = 1'b1, max_reset_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic por_req = 1'b0, warm_req = 1'b0, rd_seen = 1'b0, periph_cell_tx_enable = 1'b0;
  logic periph_bus_hold = 1'b0, periph_bus_request = 1'b0, periph_host_ready = 1'b0;
  logic [7:0]  reg_addr = 8'h00, periph_z_data = 8'h00, periph_z_oe = 8'h00, zgroup_out, zgroup_oe;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [4:0]  periph_cell_tx_data = 5'h00, cell_tx_data_out, pll_multiplier, pre_divider;
  logic [4:0]  secondary_pll_mult;
  logic [3:0]  sys_clk_tick, periph_enable;
  logic [19:0] ext_address_boot_pins, boot_addr_latched;
  logic [1:0]  ext_bank_boot_pins, boot_bank_latched;
  logic [22:0] strap_val = 23'h0, straps;
  logic        por_n, warm_reset_n, host_bus_select_pin, reset_status_out_n, cell_tx_enable_out;
  logic        ext_bus_hold_out, ext_bus_request_out, host_ready_out, pll_enable_out;
  logic        system_reference_clock, core_clk_tick, secondary_sys_clock_a, boot_host_sel_latched;
  logic [5:0]  tk;
  logic [31:0] exp_q[$];
  int bad_count = 0, n_checks = 0, n, p, r;

  assign tk = {secondary_sys_clock_a, core_clk_tick, sys_clk_tick};
  assign {host_bus_select_pin, ext_bank_boot_pins, ext_address_boot_pins} = straps;

  always #50 clk = ~clk;
  board_supervisor sup (.clk, .por_req, .warm_req, .strap_val, .por_n, .warm_reset_n, .straps);
  reset_pin_state_and_clock_tree #(.INIT_CYCLES(INIT)) uut (.*);

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one-cycle write (w=1) or read (w=0, d is the expected word)
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w) exp_q.push_back(d);
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  // read data stand only in the cycle after the read edge
  always @(posedge clk) rd_seen <= reg_rd;
  always @(negedge clk) if (rd_seen) chk("reg_rdata", exp_q.pop_front(), reg_rdata);

  task settle(output int c);
    c = 0;
    while (reset_status_out_n !== 1'b1 && c < 30000) begin
      @(negedge clk);
      c++;
    end
  endtask

  // board reset pulse, then cycles from release to status high
  task boot(input logic w, input logic [22:0] s);
    @(posedge clk);
    strap_val <= s;
    por_req <= !w;
    warm_req <= w;
    @(posedge clk);
    por_req <= 1'b0;
    warm_req <= 1'b0;
    @(negedge clk);
    while (por_n !== 1'b1 || warm_reset_n !== 1'b1) @(negedge clk);
    settle(n);
  endtask

  // spacing of two ticks of one clock
  task per(input int b, output int q);
    q = 0;
    // let a ratio change settle and stay clear of the launching edge
    repeat (4) @(negedge clk);
    while (tk[b] !== 1'b1 && q < 64) begin
      @(negedge clk);
      q++;
    end
    q = 0;
    do begin
      @(negedge clk);
      q++;
    end while (tk[b] !== 1'b1 && q < 64);
  endtask

  // new random peripheral drive, then let it reach the pins
  task setp;
    @(posedge clk);
    {periph_z_data, periph_z_oe} <= 16'($urandom);
    {periph_cell_tx_data, periph_cell_tx_enable, periph_bus_hold} <= 7'($urandom);
    {periph_bus_request, periph_host_ready} <= 2'($urandom);
    repeat (3) @(negedge clk);
  endtask

  task end_sim;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog
  initial begin
    #1000000;
    bad_count++;
    end_sim;
  end

  // main sequence
  initial begin
    void'($urandom(18));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    r = $urandom;
    boot(1'b0, 23'(r));
    chk("por_rise", INIT + 1, n);
    chk("latched", r[22:0], {boot_host_sel_latched, boot_bank_latched, boot_addr_latched});
    chk("sys_ref", 1'b1, system_reference_clock);
    acc(1'b0, `OFS_BOOT_ADDR, {12'h000, r[19:0]});
    acc(1'b0, `OFS_STATUS, {26'h0, r[21:20], r[22], 3'b011});
    setp;
    chk("z_oe", 8'h00, zgroup_oe);
    chk("low_grp", 6'h00, {cell_tx_data_out, cell_tx_enable_out});
    chk("high_grp", 3'h7, {ext_bus_hold_out, ext_bus_request_out, host_ready_out});
    chk("periph_en", 4'h0, periph_enable);
    for (int a = 4; a <= 20; a += 4) acc(1'b0, 8'(a), 32'h0);
    acc(1'b0, 8'h20, 32'h0);
    per(4, p); chk("core_div", 3, p);
    per(0, p); chk("sys2_div", 3, p);
    per(1, p); chk("sys3_div", 6, p);
    per(5, p); chk("sec_sys_a", 2, p);
    chk("sec_mult", 5'h0a, secondary_pll_mult);
    acc(1'b1, `OFS_PERIPH_CFG, 32'h1);
    setp;
    chk("bus_req", periph_bus_request, ext_bus_request_out);
    chk("host_rdy", 1'b1, host_ready_out);
    chk("bus_hold", periph_bus_hold, ext_bus_hold_out);
    acc(1'b1, `OFS_PERIPH_CFG, 32'hf);
    setp;
    chk("z_follow", periph_z_oe, zgroup_oe);
    chk("z_data", periph_z_data, zgroup_out);
    chk("cell_data", periph_cell_tx_data, cell_tx_data_out);
    chk("cell_en", periph_cell_tx_enable, cell_tx_enable_out);
    chk("host_follow", periph_host_ready, host_ready_out);
    // read-only word ignores writes
    acc(1'b1, `OFS_STATUS, 32'h0);
    acc(1'b0, `OFS_STATUS, {26'h0, r[21:20], r[22], 3'b011});
    for (int d = 4; d < 6; d++) begin
      r = $urandom_range(1, 9);
      acc(1'b1, 8'(d * 4), 32'h8000 | 32'(r));
      per(d - 2, p);
      chk("div_out", r + 1, p);
    end
    // multiplier and pre-divider reach their outputs
    r = $urandom;
    acc(1'b1, `OFS_PLL_MULT, 32'(r));
    acc(1'b1, `OFS_PRE_DIV, 32'(r >> 5));
    @(negedge clk);
    chk("mult", r[4:0], pll_multiplier);
    chk("pre_divider", r[9:5], pre_divider);
    acc(1'b1, `OFS_PLL_CTRL, 32'h1);
    per(4, p); chk("pll_mode", 1, p);
    r = $urandom;
    boot(1'b1, 23'(r));
    chk("warm_rise", INIT + 1, n);
    chk("cfg_kept", 4'hf, periph_enable);
    chk("mult_rst", 5'h00, pll_multiplier);
    acc(1'b0, `OFS_PLL_CTRL, 32'h0);
    acc(1'b0, `OFS_STATUS, {26'h0, r[21:20], r[22], 3'b101});
    per(4, p); chk("core_warm", 3, p);
    acc(1'b1, `OFS_PLL_CTRL, 32'h1);
    @(posedge clk);
    max_reset_req <= 1'b1;
    @(posedge clk);
    max_reset_req <= 1'b0;
    @(negedge clk);
    settle(n);
    chk("max_rise", 1, n >= INIT + 24 && n <= INIT + 28);
    chk("max_pll", 1'b0, pll_enable_out);
    end_sim;
  end
endmodule // reset_pin_state_and_clock_tree_tb
`default_nettype wire

// File: reset_seq_regs.vh
`ifndef RESET_SEQ_REGS_VH
`define RESET_SEQ_REGS_VH

// ************************************************************
// register offsets (byte addresses, one word each)
// ************************************************************
`define OFS_PERIPH_CFG    8'h00
`define OFS_PLL_CTRL      8'h04
`define OFS_PLL_MULT      8'h08
`define OFS_PRE_DIV       8'h0c
`define OFS_DIV_FOUR      8'h10
`define OFS_DIV_FIVE      8'h14
`define OFS_STATUS        8'h18
`define OFS_BOOT_ADDR     8'h1c

// ************************************************************
// field positions
// ************************************************************
`define PCFG_EXT_MEM      0
`define PCFG_CELL_TX      1
`define PCFG_HOST         2
`define PCFG_ZGROUP       3
`define PCFG_WIDTH        4
`define PLL_EN_BIT        0
`define DIV_EN_BIT        15
`define DIV_RATIO_W       5
`define ST_RUN_BIT        0
`define ST_POR_BIT        1
`define ST_WARM_BIT       2
`define ST_HOST_SEL_BIT   3
`define ST_BANK_LSB       4

// ************************************************************
// reset values and fixed ratios (ratio field n divides by n+1)
// ************************************************************
`define PCFG_RESET        4'h0
`define PLL_MULT_RESET    5'h00
`define PRE_DIV_RESET     5'h00
`define DIV_RATIO_RESET   5'h00
`define DIV_EN_RESET      1'b0
`define DIV_TWO_RATIO     5'h02
`define DIV_THREE_RATIO   5'h05
`define CORE_BYPASS_RATIO 5'h02
`define CORE_PLL_RATIO    5'h00
`define SEC_PLL_MULT      5'h0a
`define SEC_SYS_A_RATIO   5'h01

// ************************************************************
// timing: figures in reference periods, clock period in ns
// ************************************************************
`define CLK_PERIOD_NS     100
`define REF_PERIOD_NS     100
`define STAT_MAX_PERIODS  15000
`define WARM_MIN_PERIODS  24
`define STAT_MAX_CYCLES   ((`STAT_MAX_PERIODS * `REF_PERIOD_NS) / `CLK_PERIOD_NS)
`define WARM_MIN_CYCLES   ((`WARM_MIN_PERIODS * `REF_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STAT_MARGIN       16

`endif
